// ==== pkg/instr_decode_pkg.sv ====
// Function
// - every instruction is taken as one 14-bit word of opcode bits and operand bits.
// - every word is sorted into byte-oriented, bit-oriented or literal/control class.
// - a byte operation sends its result to the accumulator when the target bit is 0, to the register when 1.
// - the register location operand addresses locations 0x00 to 0x7F and picks the operand register.
// - a bit operation picks one of the eight bits of the addressed register by its position field.
// - a literal or control operation carries an immediate of 8 or 11 bits, by instruction.
// - opcode bits marked ignored match either value; tools should emit them as 0.
// - each instruction takes one cycle, or two with a no-operation second when a test succeeds or the pc changes.
// - each instruction cycle is exactly four consecutive oscillator periods.
// - a read-modify-write of a port register takes the pin levels as source, not the output latch.
// - writing the timer count register clears the prescaler when the prescaler is assigned to the timer.
package instr_decode_pkg;

    // ==========================================================
    // word layout
    localparam int INSTR_W   = 14;
    localparam int LOC_W     = 7;
    localparam int BITSEL_W  = 3;
    localparam int LIT_W     = 11;
    localparam int LIT_NARROW_W = 8;
    localparam int DEST_BIT  = 7;
    localparam int LOC_LSB   = 0;
    localparam int BITSEL_LSB = 7;
    localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;

    // ==========================================================
    // sequencer
    localparam int QPER_CYCLE = 4;

    // ==========================================================
    // register port
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_LOCS   = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 4'hC;
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_PRESC_BIT = 1;
    localparam int LOCS_TIMER_LSB = 0;
    localparam int LOCS_PORTA_LSB = 8;
    localparam int LOCS_PORTB_LSB = 16;
    localparam logic [LOC_W-1:0] TIMER_LOC_RST = 7'h01;
    localparam logic [LOC_W-1:0] PORTA_LOC_RST = 7'h05;
    localparam logic [LOC_W-1:0] PORTB_LOC_RST = 7'h06;
    localparam logic             RUN_RST       = 1'b0;
    localparam logic             PRESC_RST     = 1'b0;

    typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LITCTL} instrClass_t;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

endpackage

// ==== pkg/decode_if.sv ====
interface decode_if;
    import instr_decode_pkg::*;
    logic [INSTR_W-1:0] word;
    logic               load;
    logic               forceNop;
    logic [LOC_W-1:0]   timerLoc;
    logic [LOC_W-1:0]   portLocA;
    logic [LOC_W-1:0]   portLocB;
    logic               prescOn;
    instrClass_t        cls;
    logic [LOC_W-1:0]   loc;
    logic               toFile;
    logic [BITSEL_W-1:0] bitSel;
    logic [LIT_W-1:0]   literal;
    logic               litWide;
    logic               pcChange;
    logic               skipType;
    logic               isNop;
    logic               portSrc;
    logic               timerClr;

    modport decoder (input word, load, forceNop, timerLoc, portLocA, portLocB, prescOn,
                     output cls, loc, toFile, bitSel, literal, litWide, pcChange, skipType, isNop,
                     portSrc, timerClr);
    modport sequencer (output word, load, forceNop, timerLoc, portLocA, portLocB, prescOn,
                       input cls, loc, toFile, bitSel, literal, litWide, pcChange, skipType, isNop,
                       portSrc, timerClr);
endinterface

// ==== hw/instr_field_decode.sv ====
module instr_field_decode
    import instr_decode_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // decode carrier
    decode_if.decoder dec
);

    // ==========================================================
    // opcode sorting
    // three classes, ignored bits match
    function automatic instrClass_t classOf(input logic [INSTR_W-1:0] w);
        instrClass_t c;
        casez (w)
            14'b00_0000_0???_????: c = CLS_LITCTL;
            14'b00_????_????_????: c = CLS_BYTE;
            14'b01_????_????_????: c = CLS_BIT;
            default:               c = CLS_LITCTL;
        endcase
        return c;
    endfunction

    // branches, calls and returns change the pc
    function automatic logic pcChangeOf(input logic [INSTR_W-1:0] w);
        logic r;
        casez (w)
            14'b10_????_????_????: r = 1'b1;
            14'b11_01??_????_????: r = 1'b1;
            14'b00_0000_0000_100?: r = 1'b1;
            default:               r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic skipOf(input logic [INSTR_W-1:0] w);
        logic r;
        casez (w)
            14'b00_1011_????_????: r = 1'b1;
            14'b00_1111_????_????: r = 1'b1;
            14'b01_1???_????_????: r = 1'b1;
            default:               r = 1'b0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // next values
    instrClass_t         cls_d, cls_q;
    logic [LOC_W-1:0]    loc_d, loc_q;
    logic                toFile_d, toFile_q, litWide_d, litWide_q;
    logic [BITSEL_W-1:0] bitSel_d, bitSel_q;
    logic [LIT_W-1:0]    lit_d, lit_q;
    logic                pcChg_d, pcChg_q, skip_d, skip_q, nop_d, nop_q;
    logic                portSrc_d, portSrc_q, tClr_d, tClr_q;
    logic                writesLoc;

    always_comb
    begin
        writesLoc = 1'b0;
        cls_d     = cls_q;
        loc_d     = loc_q;
        toFile_d  = toFile_q;
        bitSel_d  = bitSel_q;
        lit_d     = lit_q;
        litWide_d = litWide_q;
        pcChg_d   = pcChg_q;
        skip_d    = skip_q;
        nop_d     = nop_q;
        portSrc_d = portSrc_q;
        tClr_d    = 1'b0;
        if (dec.load)
        begin
            cls_d     = classOf(dec.word);
            loc_d     = dec.word[LOC_LSB +: LOC_W];
            toFile_d  = dec.word[DEST_BIT];
            bitSel_d  = dec.word[BITSEL_LSB +: BITSEL_W];
            litWide_d = (dec.word[13:12] == 2'b10);
            lit_d     = litWide_d ? dec.word[LIT_W-1:0]
                                  : {3'h0, dec.word[LIT_NARROW_W-1:0]};
            pcChg_d   = pcChangeOf(dec.word);
            skip_d    = skipOf(dec.word);
            nop_d     = dec.forceNop;
            // byte op with target bit set, or bit set/clear
            writesLoc = ((cls_d == CLS_BYTE) && toFile_d) || (dec.word[13:11] == 3'b010);
            portSrc_d = !dec.forceNop && (cls_d != CLS_LITCTL)
                        && (loc_d == dec.portLocA || loc_d == dec.portLocB);
            tClr_d    = !dec.forceNop && writesLoc && dec.prescOn && (loc_d == dec.timerLoc);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cls_q     <= CLS_LITCTL;
            loc_q     <= '0;
            toFile_q  <= 1'b0;
            bitSel_q  <= '0;
            lit_q     <= '0;
            litWide_q <= 1'b0;
            pcChg_q   <= 1'b0;
            skip_q    <= 1'b0;
            nop_q     <= 1'b1;
            portSrc_q <= 1'b0;
            tClr_q    <= 1'b0;
        end
        else
        begin
            cls_q     <= cls_d;
            loc_q     <= loc_d;
            toFile_q  <= toFile_d;
            bitSel_q  <= bitSel_d;
            lit_q     <= lit_d;
            litWide_q <= litWide_d;
            pcChg_q   <= pcChg_d;
            skip_q    <= skip_d;
            nop_q     <= nop_d;
            portSrc_q <= portSrc_d;
            tClr_q    <= tClr_d;
        end
    end

    assign dec.cls      = cls_q;
    assign dec.loc      = loc_q;
    assign dec.toFile   = toFile_q;
    assign dec.bitSel   = bitSel_q;
    assign dec.literal  = lit_q;
    assign dec.litWide  = litWide_q;
    assign dec.pcChange = pcChg_q;
    assign dec.skipType = skip_q;
    assign dec.isNop    = nop_q;
    assign dec.portSrc  = portSrc_q;
    assign dec.timerClr = tClr_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    AST_DEST_FROM_BIT7: assert property (dec.load && dec.word[13:12] == 2'b00 |=>
        dec.toFile == $past(dec.word[7])) else $error("target bit not taken from bit 7");
    AST_LOC_FIELD: assert property (dec.load && !dec.word[13] |=>
        dec.loc == $past(dec.word[6:0])) else $error("location field wrong");
    AST_BIT_FIELD: assert property (dec.load && dec.word[13:12] == 2'b01 |=>
        dec.cls == CLS_BIT && dec.bitSel == $past(dec.word[9:7])) else $error("bit position wrong");
    AST_WIDE_LIT: assert property (dec.load && dec.word[13:12] == 2'b10 |=>
        dec.litWide && dec.literal == $past(dec.word[10:0])) else $error("wide literal wrong");
    AST_NARROW_LIT: assert property (dec.load && dec.word[13:12] == 2'b11 |=>
        !dec.litWide && dec.literal[10:8] == 3'h0 && dec.literal[7:0] == $past(dec.word[7:0]))
        else $error("narrow literal wrong");
    AST_IGNORED_BITS: assert property (dec.load && dec.word[13:7] == 7'h00 |=>
        dec.cls == CLS_LITCTL) else $error("control word with ignored bits misclassed");
    AST_BYTE_CLASS: assert property (dec.load && dec.word[13:12] == 2'b00 && dec.word[11:8] != 4'h0 |=>
        dec.cls == CLS_BYTE) else $error("byte word misclassed");
    AST_PIN_SOURCE: assert property (dec.load && !dec.forceNop && !dec.word[13] && dec.word[12:7] != 6'h00
        && dec.word[6:0] == dec.portLocA |=> dec.portSrc) else $error("port read not from pins");

endmodule

// ==== hw/instr_word_decode_timing.sv ====
module instr_word_decode_timing
    import instr_decode_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // program memory
    input  wire logic [INSTR_W-1:0]  instrWord,
    output logic                     fetchStrobe,
    // datapath feedback
    input  wire logic                testTrue,
    input  wire logic                pcWrite,
    // decoded controls
    output logic [1:0]               qPhase,
    output logic                     cycleEnd,
    output logic                     execNop,
    output instrClass_t              instrClass,
    output logic [LOC_W-1:0]         regLoc,
    output logic                     toFile,
    output logic [BITSEL_W-1:0]      bitSel,
    output logic [LIT_W-1:0]         literal,
    output logic                     litWide,
    output logic                     srcFromPins,
    output logic                     clrPrescaler,
    // register port
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [DATA_W-1:0]   regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic [DATA_W-1:0]        regRdata
);

    decode_if dec ();

    instr_field_decode u_decode (
        .clk_sys (clk_sys),
        .srst    (srst),
        .dec     (dec)
    );

    // ==========================================================
    // control registers
    logic             run_d, run_q, presc_d, presc_q;
    logic [LOC_W-1:0] tLoc_d, tLoc_q, pA_d, pA_q, pB_d, pB_q;
    logic [DATA_W-1:0] rdata_d, rdata_q;
    logic [31:0]      count_d, count_q;

    // ==========================================================
    // quarter sequencer
    phase_t phase_d, phase_q;
    logic   flushPend_d, flushPend_q, flushNow;

    always_comb
    begin
        phase_d = phase_q;
        if (!run_q)
            phase_d = PH_Q1;
        else
        begin
            case (phase_q)
                PH_Q1:   phase_d = PH_Q2;
                PH_Q2:   phase_d = PH_Q3;
                PH_Q3:   phase_d = PH_Q4;
                PH_Q4:   phase_d = PH_Q1;
                default: phase_d = PH_Q1;
            endcase
        end
    end

    assign cycleEnd    = run_q && (phase_q == PH_Q4);
    assign fetchStrobe = cycleEnd;

    // a no-operation cycle cannot itself flush; feedback seen then is stale
    // flush on pc change or true test
    assign flushNow = cycleEnd && !dec.isNop
                      && (dec.pcChange || flushPend_q || pcWrite || (dec.skipType && testTrue));

    always_comb
    begin
        flushPend_d = flushPend_q;
        if (cycleEnd)
            flushPend_d = 1'b0;
        else if (run_q && !dec.isNop && (pcWrite || (dec.skipType && testTrue)))
            flushPend_d = 1'b1;
    end

    // fetched word replaced by a no-operation
    assign dec.load     = cycleEnd;
    assign dec.forceNop = flushNow;
    assign dec.word     = flushNow ? NOP_WORD : instrWord;
    assign dec.timerLoc = tLoc_q;
    assign dec.portLocA = pA_q;
    assign dec.portLocB = pB_q;
    assign dec.prescOn  = presc_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            phase_q     <= PH_Q1;
            flushPend_q <= 1'b0;
        end
        else
        begin
            phase_q     <= phase_d;
            flushPend_q <= flushPend_d;
        end
    end

    // ==========================================================
    // register port
    always_comb
    begin
        run_d   = run_q;
        presc_d = presc_q;
        tLoc_d  = tLoc_q;
        pA_d    = pA_q;
        pB_d    = pB_q;
        count_d = count_q;
        rdata_d = '0;
        if (cycleEnd && !dec.isNop)
            count_d = count_q + 32'h0000_0001;
        if (regWr)
        begin
            case (regAddr)
                REG_CTRL:
                begin
                    run_d   = regWdata[CTRL_RUN_BIT];
                    presc_d = regWdata[CTRL_PRESC_BIT];
                end
                REG_LOCS:
                begin
                    tLoc_d = regWdata[LOCS_TIMER_LSB +: LOC_W];
                    pA_d   = regWdata[LOCS_PORTA_LSB +: LOC_W];
                    pB_d   = regWdata[LOCS_PORTB_LSB +: LOC_W];
                end
                default: ;
            endcase
        end
        if (regRd)
        begin
            case (regAddr)
                REG_CTRL:   rdata_d = DATA_W'({presc_q, run_q});
                REG_LOCS:   rdata_d = DATA_W'({1'b0, pB_q, 1'b0, pA_q, 1'b0, tLoc_q});
                REG_STATUS: rdata_d = DATA_W'({flushPend_q, dec.isNop, dec.cls, phase_q});
                REG_COUNT:  rdata_d = DATA_W'(count_q);
                default:    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            run_q   <= RUN_RST;
            presc_q <= PRESC_RST;
            tLoc_q  <= TIMER_LOC_RST;
            pA_q    <= PORTA_LOC_RST;
            pB_q    <= PORTB_LOC_RST;
            count_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            run_q   <= run_d;
            presc_q <= presc_d;
            tLoc_q  <= tLoc_d;
            pA_q    <= pA_d;
            pB_q    <= pB_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // outputs
    assign qPhase       = phase_q;
    assign execNop      = dec.isNop;
    assign instrClass   = dec.cls;
    assign regLoc       = dec.loc;
    assign toFile       = dec.toFile;
    assign bitSel       = dec.bitSel;
    assign literal      = dec.literal;
    assign litWide      = dec.litWide;
    assign srcFromPins  = dec.portSrc;
    assign clrPrescaler = dec.timerClr;
    assign regRdata     = rdata_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence quarterWalk;
        phase_q == PH_Q2 ##1 phase_q == PH_Q3 ##1 phase_q == PH_Q4;
    endsequence

    sequence runFromQ1;
        run_q && phase_q == PH_Q1;
    endsequence

    // a stop written mid-cycle ends the walk early, so only a held run must reach Q4
    AST_FOUR_PERIODS: assert property (runFromQ1 ##1 run_q[*2] |=> phase_q == PH_Q4)
        else $error("quarter walk broken");
    AST_QUARTER_ORDER: assert property (runFromQ1 |=> quarterWalk or (##[0:1] !run_q))
        else $error("quarters out of order");
    AST_CYCLE_GAP: assert property (cycleEnd |=> !cycleEnd[*3])
        else $error("instruction cycle shorter than four periods");
    AST_PC_FLUSH: assert property (cycleEnd && dec.pcChange && !dec.isNop |=> execNop)
        else $error("pc change did not discard fetched word");
    AST_SKIP_FLUSH: assert property (cycleEnd && dec.skipType && testTrue && !dec.isNop |=> execNop)
        else $error("true test did not add a no-operation cycle");
    AST_SINGLE_CYCLE: assert property (cycleEnd && !dec.pcChange && !flushPend_q && !testTrue && !pcWrite
        |=> !execNop) else $error("plain instruction took two cycles");
    AST_NOP_NOT_CHAINED: assert property (cycleEnd && execNop |=> !execNop)
        else $error("no-operation cycle repeated");
    AST_PRESC_CLEAR: assert property (clrPrescaler |-> $past(presc_q) && $past(cycleEnd) ##1 !clrPrescaler)
        else $error("prescaler clear without assignment or too long");

endmodule

// ==== dv/prog_mem_model.sv ====
module prog_mem_model
    import instr_decode_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // fetch side
    input  wire logic                fetchStrobe,
    output logic [INSTR_W-1:0]       instrWord
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // storage, filled by the bench before the run starts
    logic [INSTR_W-1:0] mem [0:63];
    int                 ptr;

    // whole 14-bit word
    // memory drives the next word continuously, as a real array would
    assign instrWord = mem[ptr[5:0]];

    // no refetch after a discard: the bench plans around the lost word
    always @(posedge clk_sys)
    begin
        if (srst)
            ptr <= 0;
        else if (fetchStrobe)
            ptr <= ptr + 1;
    end
endmodule

// ==== dv/tb.sv ====
module tb;
    import instr_decode_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [13:0] w; bit nop; bit tt; bit pw;} note_t;

    // ==========================================================
    // signals
    logic                clk_sys, srst, fetchStrobe, testTrue, pcWrite, cycleEnd, execNop;
    logic [INSTR_W-1:0]  instrWord;
    logic [1:0]          qPhase;
    instrClass_t         instrClass;
    logic [LOC_W-1:0]    regLoc;
    logic                toFile, litWide, srcFromPins, clrPrescaler, regWr, regRd, rdPend, newSlot;
    logic [BITSEL_W-1:0] bitSel;
    logic [LIT_W-1:0]    literal;
    logic [ADDR_W-1:0]   regAddr;
    logic [31:0]         regWdata, regRdata;
    int                  numErrors, nChecks, seed, cycles, gap;
    bit                  gapValid, skipNext;
    logic                runQ = 1'b0;
    note_t               notes[$];
    logic [31:0]         rdQ[$];
    // tt, pw, word: fixed cases at the awkward corners
    logic [15:0]         fixed [0:13] = '{16'h0081, 16'h1001, 16'h0805, 16'h8B81, 16'h1C86, 16'h2ABC,
                                          16'h3705, 16'h0008, 16'h0009, 16'h3E12, 16'h3F12, 16'h0060,
                                          16'h4786, 16'h9A06};

    instr_word_decode_timing i_dut (.clk_sys(clk_sys), .srst(srst), .instrWord(instrWord),
        .fetchStrobe(fetchStrobe), .testTrue(testTrue), .pcWrite(pcWrite), .qPhase(qPhase),
        .cycleEnd(cycleEnd), .execNop(execNop), .instrClass(instrClass), .regLoc(regLoc),
        .toFile(toFile), .bitSel(bitSel), .literal(literal), .litWide(litWide),
        .srcFromPins(srcFromPins), .clrPrescaler(clrPrescaler), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

    prog_mem_model i_mem (.clk_sys(clk_sys), .srst(srst), .fetchStrobe(fetchStrobe), .instrWord(instrWord));

    always #20 clk_sys = ~clk_sys;

    // ==========================================================
    // compare and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        nChecks++;
        if (seen !== expv)
        begin
            numErrors++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, expv);
        end
    endtask

    task automatic printVerdict();
        if (numErrors == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic bit flushOf(logic [13:0] w, bit tt, bit pw);
        return pw || w[13:12] == 2'b10 || w[13:10] == 4'b1101 || w[13:1] == 13'h0004 ||
               (tt && (w[13:8] == 6'h0B || w[13:8] == 6'h0F || w[13:11] == 3'b011));
    endfunction

    task automatic checkSlot(input note_t n);
        logic [13:0] w;
        instrClass_t c;
        logic        wide, portHit, timerWr;
        w = n.w;
        wide = w[13:12] == 2'b10;
        c = (w[13:12] == 2'b01) ? CLS_BIT : ((w[13:12] == 2'b00 && w[11:7] != 5'h00) ? CLS_BYTE : CLS_LITCTL);
        portHit = c != CLS_LITCTL && (w[6:0] == PORTA_LOC_RST || w[6:0] == PORTB_LOC_RST) && !n.nop;
        timerWr = ((c == CLS_BYTE && w[7]) || (c == CLS_BIT && !w[11])) && w[6:0] == TIMER_LOC_RST && !n.nop;
        check({30'h0, instrClass}, {30'h0, c});
        check({31'h0, toFile}, {31'h0, w[7]});
        check({25'h0, regLoc}, {25'h0, w[6:0]});
        check({29'h0, bitSel}, {29'h0, w[9:7]});
        check({31'h0, litWide}, {31'h0, wide});
        check({21'h0, literal}, wide ? {21'h0, w[10:0]} : {24'h0, w[7:0]});
        check({31'h0, execNop}, {31'h0, n.nop});
        check({31'h0, srcFromPins}, {31'h0, portHit});
        check({31'h0, clrPrescaler}, {31'h0, timerWr});
    endtask

    // ==========================================================
    // watcher: takes the oldest note at each new instruction cycle
    always @(posedge clk_sys)
    begin
        cycles++;
        gap++;
        if (rdPend)
            check(regRdata, rdQ.pop_front());
        rdPend <= regRd;
        if (regWr && regAddr == REG_CTRL)
            runQ <= regWdata[CTRL_RUN_BIT];
        if (cycles > 1)
        begin
            check({31'h0, fetchStrobe}, {31'h0, runQ && qPhase == 2'h3});
            check({31'h0, cycleEnd}, {31'h0, runQ && qPhase == 2'h3});
        end
        if (newSlot && notes.size() > 0)
        begin
            if (gapValid) check(gap, 32'h0000_0004);
            gap = 0;
            gapValid = 1;
            checkSlot(notes[0]);
            // feedback lands in Q2, well inside the instruction cycle
            testTrue <= notes[0].tt;
            pcWrite <= notes[0].pw;
            void'(notes.pop_front());
        end
        else
        begin
            testTrue <= 1'b0;
            pcWrite <= 1'b0;
        end
        newSlot = (cycleEnd === 1'b1);
        if (cycles > 4000)
        begin
            numErrors++;
            printVerdict();
        end
    end

    // ==========================================================
    // register port
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        rdQ.push_back(e);
        @(posedge clk_sys);
        regRd <= 1'b0;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        note_t n;
        logic [15:0] v;
        clk_sys = 1'b0;
        srst = 1'b1;
        regAddr = 4'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        testTrue = 1'b0;
        pcWrite = 1'b0;
        rdPend = 1'b0;
        newSlot = 1'b0;
        numErrors = 0;
        nChecks = 0;
        seed = 55;
        cycles = 0;
        gap = 0;
        for (int i = 0; i < 64; i++)
        begin
            v = (i < 14) ? fixed[i] : {$random(seed)} % 32'h10000;
            if (i >= 14)
                v[14] = (($random(seed) & 7) == 0);
            i_mem.mem[i] = (i < 44) ? v[13:0] : 14'h0000;
            // a word fetched behind a flush is lost, so it gets no note
            if (i >= 44 || skipNext)
            begin
                skipNext = 0;
                continue;
            end
            n = '{v[13:0], 1'b0, v[15], v[14]};
            notes.push_back(n);
            if (flushOf(v[13:0], v[15], v[14]))
            begin
                // feedback during a forced nop must not stretch it
                n = '{14'h0000, 1'b1, 1'b0, 1'($random(seed))};
                notes.push_back(n);
                skipNext = 1;
            end
        end
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        regRead(REG_LOCS, 32'h0006_0501);
        regRead(4'h2, 32'h0000_0000);
        regWrite(REG_CTRL, 32'h0000_0003);
        regRead(REG_CTRL, 32'h0000_0003);
        while (notes.size() > 0)
            @(posedge clk_sys);
        regWrite(REG_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        check({30'h0, qPhase}, 32'h0000_0000);
        printVerdict();
    end
endmodule
